// [rtl/pms_pkg.sv]
// Constants, encodings and types shared by both ends of the serial management port.
// Assumes a single 125 MHz system clock in each end and an external pull-up on the data line.
//
// Overview of operation
// - Station clocks at most 25MHz, may stop idle
// - Receiver samples data on rising management clock
// - Bus address caught from straps at reset
// - Station stays idle one clock after reset
// - Direct frame reaches 32 sixteen-bit registers
// - Frame starts with 0 then 1 after ones
// - Read turnaround: release, then 0, then data
// - Write turnaround 10 driven by station only
// - Indirect access to registers 13, 14 ignored
// - Registers 0-31 except 13, 14 also reachable indirectly
// - Indirect data acts only when target field 11111
// - Function field selects address or data modes
// - Function 00 write loads the pointer
// - Function 00 read returns the pointer
// - Function 01 accesses pointed register, no increment
// - Function 10 increments after reads and writes
// - Function 11 increments after writes only
// - Station sequence 001F, address, 401F, data
// - Station sets pointer before first extended access
package pms_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int MDC_MAX_MHZ   = 25;
   // Least half period at the fastest legal management clock, rounded up
   localparam int MDC_HALF_MIN  = (1000 + 2 * MDC_MAX_MHZ * CLK_PERIOD_NS - 1) / (2 * MDC_MAX_MHZ * CLK_PERIOD_NS);
   // Device samples through synchronisers, so the station default is slower than the legal limit
   localparam int MDC_HALF_DEF  = 8;
   localparam int PRE_BITS      = 32;

   // ****************************************
   // Frame layout
   // ****************************************
   localparam int BUS_AW    = 5;
   localparam int REG_W     = 16;
   localparam int HDR_BITS  = 12;
   localparam int TA_BITS   = 2;
   localparam int DATA_BITS = 16;
   localparam int FRAME_BITS = 32;
   localparam logic [1:0] START_PAT = 2'h1;
   localparam logic [1:0] OP_READ   = 2'h2;
   localparam logic [1:0] OP_WRITE  = 2'h1;
   localparam logic [1:0] TA_WRITE  = 2'h2;
   localparam logic [1:0] TA_READ   = 2'h3;
   localparam logic [3:0] HDR_LAST  = 4'hB;
   localparam logic [3:0] TA_LAST   = 4'h1;
   localparam logic [3:0] DATA_LAST = 4'hF;

   // ****************************************
   // Registers
   // ****************************************
   localparam logic [4:0] REG_ACCESS_CONTROL = 5'h0D;
   localparam logic [4:0] REG_ADDRESS_DATA   = 5'h0E;
   localparam int FUNC_MSB  = 15;
   localparam int FUNC_LSB  = 14;
   localparam int TARGET_DEVICE_FIELD_MSB = 4;
   localparam logic [4:0] TARGET_DEVICE_FIELD_OWN = 5'h1F;
   localparam int MEM_WORDS = 64;
   localparam int MEM_AW    = 6;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] CTRL_SET_ADDR = 16'h001F;
   localparam logic [15:0] CTRL_SET_DATA = 16'h401F;

   typedef enum logic [1:0] {
      FN_ADDR        = 2'b00,
      FN_DATA        = 2'b01,
      FN_DATA_INC_RW = 2'b10,
      FN_DATA_INC_WR = 2'b11
   } pms_func_type;

   typedef enum logic [2:0] {
      D_IDLE  = 3'b000,
      D_START = 3'b001,
      D_HDR   = 3'b010,
      D_TA    = 3'b011,
      D_DATA  = 3'b100
   } pms_dev_state_type;

   typedef enum logic [1:0] {
      S_HOLD = 2'b00,
      S_IDLE = 2'b01,
      S_LOW  = 2'b10,
      S_HIGH = 2'b11
   } pms_sta_state_type;

endpackage

// [rtl/pms_mgmt_if.sv]
// Management clock and shared data line between station and device.
// Assumes the bench instantiates it once; the pull-up is modelled as a default high.
`timescale 1ns/100ps
interface pms_mgmt_if;
   logic mdc;
   logic sta_mdio_val;
   logic sta_mdio_en;
   logic dev_mdio_val;
   logic dev_mdio_en;
   logic mdio;

   // Undriven line floats high through the pull-up
   assign mdio = dev_mdio_en ? dev_mdio_val : (sta_mdio_en ? sta_mdio_val : 1'b1);

   modport station (output mdc, output sta_mdio_val, output sta_mdio_en, input mdio);
   modport device  (input mdc, input mdio, output dev_mdio_val, output dev_mdio_en);
endinterface

// [rtl/pms_mgmt_device.sv]
// Device end: frame decoder, direct register file and indirect extended access.
// Assumes the management clock and data line are asynchronous to sys_clk and much slower.
`timescale 1ns/100ps
module pms_mgmt_device (
   input  wire logic                        sys_clk,
   input  wire logic                        rstn,
   input  wire logic [pms_pkg::BUS_AW-1:0]  bus_address_straps,
   pms_mgmt_if.device                       mgmt,
   output logic      [pms_pkg::BUS_AW-1:0]  bus_address,
   output logic      [pms_pkg::REG_W-1:0]   indirect_access_control,
   output logic      [pms_pkg::REG_W-1:0]   indirect_pointer,
   output logic                             frame_done
);
   import pms_pkg::*;

   // ****************************************
   // Synchronisers and edge detect
   // ****************************************
   logic [2:0]          mdc_sync_q;
   logic [1:0]          mdio_sync_q;
   logic [BUS_AW-1:0]   strap_s1_q;
   logic [BUS_AW-1:0]   strap_s2_q;
   logic [BUS_AW-1:0]   addr_q;
   logic                rise;
   logic                bit_in;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mdc_sync_q  <= 3'h0;
         mdio_sync_q <= 2'h3;
      end else begin
         mdc_sync_q  <= {mdc_sync_q[1:0], mgmt.mdc};
         mdio_sync_q <= {mdio_sync_q[0], mgmt.mdio};
      end
   end

   // Straps keep flowing during reset so the capture below sees settled pins
   always_ff @(posedge sys_clk) begin
      strap_s1_q <= bus_address_straps;
      strap_s2_q <= strap_s1_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         addr_q <= strap_s2_q;
      end
   end

   // No edge is assumed outside frames: the clock may be gated while idle
   assign rise   = mdc_sync_q[1] & ~mdc_sync_q[2];
   assign bit_in = mdio_sync_q[1];

   // ****************************************
   // Frame state
   // ****************************************
   pms_dev_state_type   state_q;
   logic [3:0]          cnt_q;
   logic [HDR_BITS-2:0] hdr_q;
   logic [HDR_BITS-1:0] hdr_now;
   logic                hdr_end;
   logic                sel_q;
   logic                wr_q;
   logic [4:0]          reg_q;
   logic [REG_W-2:0]    wsh_q;
   logic [REG_W-1:0]    wdata_now;
   logic                commit;
   logic                hit;

   assign hdr_now   = {hdr_q, bit_in};
   assign hdr_end   = rise && (state_q == D_HDR) && (cnt_q == HDR_LAST);
   assign hit       = (hdr_now[9:5] == addr_q) && ((hdr_now[11:10] == OP_READ) || (hdr_now[11:10] == OP_WRITE));
   assign wdata_now = {wsh_q, bit_in};
   // Only the last data bit commits, so a frame cut short changes nothing
   assign commit    = rise && (state_q == D_DATA) && (cnt_q == DATA_LAST) && sel_q;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_q <= D_IDLE;
         cnt_q   <= 4'h0;
      end else if (rise) begin
         unique case (state_q)
            D_IDLE: begin
               if (!bit_in) begin
                  state_q <= D_START;
               end
            end
            D_START: begin
               if (bit_in) begin
                  state_q <= D_HDR;
                  cnt_q   <= 4'h0;
               end
            end
            D_HDR: begin
               if (cnt_q == HDR_LAST) begin
                  state_q <= D_TA;
                  cnt_q   <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            D_TA: begin
               if (cnt_q == TA_LAST) begin
                  state_q <= D_DATA;
                  cnt_q   <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            D_DATA: begin
               if (cnt_q == DATA_LAST) begin
                  state_q <= D_IDLE;
                  cnt_q   <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            default: begin
               state_q <= D_IDLE;
               cnt_q   <= 4'h0;
            end
         endcase
      end
   end

   // Frames for other addresses are still tracked to the end so data bits never look like a start
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         hdr_q <= '0;
         sel_q <= 1'b0;
         wr_q  <= 1'b0;
         reg_q <= 5'h00;
         wsh_q <= '0;
      end else if (rise) begin
         if (state_q == D_HDR) begin
            hdr_q <= hdr_now[HDR_BITS-2:0];
         end
         if (hdr_end) begin
            sel_q <= hit;
            wr_q  <= (hdr_now[11:10] == OP_WRITE);
            reg_q <= hdr_now[4:0];
         end
         if (state_q == D_DATA) begin
            wsh_q <= wdata_now[REG_W-2:0];
         end
      end
   end

   // ****************************************
   // Register file and indirect access
   // ****************************************
   logic [REG_W-1:0]    mem_q [MEM_WORDS];
   logic [REG_W-1:0]    ptr_q;
   logic [REG_W-1:0]    ptr_d;
   logic                mem_we;
   logic [MEM_AW-1:0]   mem_idx;
   logic [REG_W-1:0]    mem_wval;
   logic [REG_W-1:0]    rd_val;
   logic                ptr_ok;
   logic                target_device_field_ok;
   pms_func_type        func;

   assign func     = pms_func_type'(mem_q[REG_ACCESS_CONTROL][FUNC_MSB:FUNC_LSB]);
   assign target_device_field_ok = (mem_q[REG_ACCESS_CONTROL][TARGET_DEVICE_FIELD_MSB:0] == TARGET_DEVICE_FIELD_OWN);
   // Pointer reaches the 32 standard words and the extended words above them, never 13 or 14
   assign ptr_ok   = (ptr_q[REG_W-1:MEM_AW] == '0)
                     && (ptr_q[MEM_AW-1:0] != {1'b0, REG_ACCESS_CONTROL})
                     && (ptr_q[MEM_AW-1:0] != {1'b0, REG_ADDRESS_DATA});

   always_comb begin
      rd_val = REG_RESET;
      if (hdr_now[4:0] != REG_ADDRESS_DATA) begin
         rd_val = mem_q[{1'b0, hdr_now[4:0]}];
      end else if (target_device_field_ok) begin
         if (func == FN_ADDR) begin
            rd_val = ptr_q;
         end else if (ptr_ok) begin
            rd_val = mem_q[ptr_q[MEM_AW-1:0]];
         end
      end
   end

   always_comb begin
      mem_we   = 1'b0;
      mem_idx  = {1'b0, reg_q};
      mem_wval = wdata_now;
      ptr_d    = ptr_q;
      if (commit) begin
         if (reg_q != REG_ADDRESS_DATA) begin
            mem_we = wr_q;
         end else if (target_device_field_ok) begin
            if (func == FN_ADDR) begin
               if (wr_q) begin
                  ptr_d = wdata_now;
               end
            end else begin
               if (wr_q && ptr_ok) begin
                  mem_we  = 1'b1;
                  mem_idx = ptr_q[MEM_AW-1:0];
               end
               if ((func == FN_DATA_INC_RW) || ((func == FN_DATA_INC_WR) && wr_q)) begin
                  ptr_d = ptr_q + 16'h0001;
               end
            end
         end
      end
   end

   for (genvar i = 0; i < MEM_WORDS; i++) begin : g_reg
      always_ff @(posedge sys_clk) begin
         if (!rstn) begin
            mem_q[i] <= REG_RESET;
         end else if (mem_we && (mem_idx == MEM_AW'(i))) begin
            mem_q[i] <= mem_wval;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ptr_q <= REG_RESET;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         frame_done <= 1'b0;
      end else begin
         frame_done <= commit;
      end
   end

   // ****************************************
   // Read data drive
   // ****************************************
   logic [REG_W-1:0]    rsh_q;
   logic                drv_val_q;
   logic                drv_en_q;

   // Line changes just after the rising edge and holds until the next one where the station samples
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rsh_q     <= '0;
         drv_val_q <= 1'b0;
         drv_en_q  <= 1'b0;
      end else if (rise) begin
         if (hdr_end) begin
            rsh_q <= rd_val;
         end
         if (sel_q && !wr_q) begin
            if ((state_q == D_TA) && (cnt_q == 4'h0)) begin
               drv_en_q  <= 1'b1;
               drv_val_q <= 1'b0;
            end else if ((state_q == D_TA) || ((state_q == D_DATA) && (cnt_q != DATA_LAST))) begin
               drv_val_q <= rsh_q[REG_W-1];
               rsh_q     <= {rsh_q[REG_W-2:0], 1'b0};
            end else if (state_q == D_DATA) begin
               drv_en_q <= 1'b0;
            end
         end
      end
   end

   // Write frames never enable the driver
   assign mgmt.dev_mdio_val      = drv_val_q;
   assign mgmt.dev_mdio_en       = drv_en_q;
   assign bus_address            = addr_q;
   assign indirect_access_control = mem_q[REG_ACCESS_CONTROL];
   assign indirect_pointer       = ptr_q;

endmodule // pms_mgmt_device

// [rtl/pms_mgmt_station.sv]
// Station end: makes the gated management clock and runs one read or write frame per command.
// Assumes the user holds a command stable while cmd_valid is high and not yet accepted.
`timescale 1ns/100ps
module pms_mgmt_station #(
   parameter int MDC_HALF = pms_pkg::MDC_HALF_DEF,
   parameter int PRE_LEN  = pms_pkg::PRE_BITS
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rstn,
   pms_mgmt_if.station                      mgmt,
   input  wire logic                        cmd_valid,
   output logic                             cmd_ready,
   input  wire logic                        cmd_write,
   input  wire logic [pms_pkg::BUS_AW-1:0]  cmd_phy,
   input  wire logic [4:0]                  cmd_reg,
   input  wire logic [pms_pkg::REG_W-1:0]   cmd_wdata,
   output logic                             rsp_valid,
   output logic      [pms_pkg::REG_W-1:0]   rsp_rdata
);
   import pms_pkg::*;

   localparam int LEN = PRE_LEN + FRAME_BITS;

   // ****************************************
   // State
   // ****************************************
   pms_sta_state_type   state_q;
   logic [7:0]          div_q;
   logic [7:0]          bit_q;
   logic [LEN-1:0]      sh_q;
   logic                rd_q;
   logic [REG_W-1:0]    rsh_q;
   logic [1:0]          mdio_sync_q;
   logic                mdc_q;
   logic                val_q;
   logic                en_q;
   logic                half_end;
   logic [7:0]          nxt_bit;

   assign half_end = (div_q == 8'(MDC_HALF - 1));
   assign nxt_bit  = bit_q + 8'h01;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mdio_sync_q <= 2'h3;
      end else begin
         mdio_sync_q <= {mdio_sync_q[0], mgmt.mdio};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_q   <= S_HOLD;
         div_q     <= 8'h00;
         bit_q     <= 8'h00;
         sh_q      <= '0;
         rd_q      <= 1'b0;
         rsh_q     <= '0;
         mdc_q     <= 1'b0;
         val_q     <= 1'b1;
         en_q      <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= 1'b0;
         unique case (state_q)
            S_HOLD: begin
               // Bus stays quiet for a full clock period after reset
               div_q <= div_q + 8'h01;
               if (div_q == 8'(2 * MDC_HALF - 1)) begin
                  div_q     <= 8'h00;
                  state_q   <= S_IDLE;
                  cmd_ready <= 1'b1;
               end
            end
            S_IDLE: begin
               if (cmd_valid) begin
                  sh_q      <= {{PRE_LEN{1'b1}}, START_PAT, cmd_write ? OP_WRITE : OP_READ, cmd_phy, cmd_reg,
                                cmd_write ? TA_WRITE : TA_READ, cmd_write ? cmd_wdata : 16'h0000};
                  rd_q      <= !cmd_write;
                  bit_q     <= 8'h00;
                  div_q     <= 8'h00;
                  val_q     <= 1'b1;
                  en_q      <= 1'b1;
                  cmd_ready <= 1'b0;
                  state_q   <= S_LOW;
               end
            end
            S_LOW: begin
               div_q <= div_q + 8'h01;
               if (half_end) begin
                  div_q   <= 8'h00;
                  mdc_q   <= 1'b1;
                  state_q <= S_HIGH;
                  if (rd_q && (bit_q >= 8'(PRE_LEN + HDR_BITS + 2 + TA_BITS))) begin
                     rsh_q <= {rsh_q[REG_W-2:0], mdio_sync_q[1]};
                  end
               end
            end
            S_HIGH: begin
               div_q <= div_q + 8'h01;
               if (half_end) begin
                  div_q <= 8'h00;
                  mdc_q <= 1'b0;
                  if (bit_q == 8'(LEN - 1)) begin
                     // Clock is left stopped low between frames
                     state_q   <= S_IDLE;
                     en_q      <= 1'b0;
                     val_q     <= 1'b1;
                     cmd_ready <= 1'b1;
                     rsp_valid <= rd_q;
                     rsp_rdata <= rsh_q;
                  end else begin
                     state_q <= S_LOW;
                     bit_q   <= nxt_bit;
                     sh_q    <= {sh_q[LEN-2:0], 1'b1};
                     val_q   <= sh_q[LEN-2];
                     // Read releases the line from the first turnaround bit onward
                     if (rd_q && (nxt_bit >= 8'(PRE_LEN + HDR_BITS + 2))) begin
                        en_q <= 1'b0;
                     end
                  end
               end
            end
         endcase
      end
   end

   assign mgmt.mdc          = mdc_q;
   assign mgmt.sta_mdio_val = val_q;
   assign mgmt.sta_mdio_en  = en_q;

endmodule // pms_mgmt_station

// [testbench/pms_mgmt_sva.sv]
// Checker for the management link between station and device ends.
// Assumes instantiation beside the interface, in the system clock domain.
`timescale 1ns/100ps
module pms_mgmt_sva #(
   parameter int MDC_HALF = 6
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic mdc,
   input wire logic sta_mdio_val,
   input wire logic sta_mdio_en,
   input wire logic dev_mdio_val,
   input wire logic dev_mdio_en,
   input wire logic mdio
);
   // Turnaround zero plus 16 data bits; two cycles of slack for the synchronisers
   localparam int DRV_NOM = 17 * 2 * MDC_HALF;
   logic [9:0] drv_q;

   always_ff @(posedge sys_clk) begin
      if (!rstn || !dev_mdio_en) begin
         drv_q <= 10'h000;
      end else begin
         drv_q <= drv_q + 10'h001;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // ****************************************
   // Sequences and properties
   // ****************************************
   sequence s_ta_zero;
      (dev_mdio_en && !dev_mdio_val) [*8];
   endsequence
   sequence s_bus_free;
      !sta_mdio_en && !$past(sta_mdio_en, 8);
   endsequence

   property p_no_contention;
      !(dev_mdio_en && sta_mdio_en);
   endproperty
   property p_ta_zero;
      $rose(dev_mdio_en) |-> s_ta_zero;
   endproperty
   property p_dev_window;
      $fell(dev_mdio_en) |-> (drv_q >= DRV_NOM - 2) && (drv_q <= DRV_NOM + 2);
   endproperty
   property p_dev_released;
      $rose(dev_mdio_en) |-> s_bus_free;
   endproperty
   property p_dev_sample;
      (dev_mdio_en && $rose(mdc)) |-> $stable(dev_mdio_val);
   endproperty
   property p_sta_sample;
      (mdc && $past(mdc)) |-> $stable(sta_mdio_val) && $stable(sta_mdio_en);
   endproperty
   // High half fixed at six system cycles, the bench setting
   property p_mdc_half;
      $rose(mdc) |-> mdc [*6] ##1 !mdc;
   endproperty
   property p_reset_idle;
      $rose(rstn) |-> (!mdc && !sta_mdio_en) [*8];
   endproperty
   property p_pullup;
      (!dev_mdio_en && !sta_mdio_en) |-> mdio;
   endproperty

   a_no_contention: assert property (p_no_contention) else $error("both ends drive the data line");
   a_ta_zero: assert property (p_ta_zero) else $error("turnaround zero not held");
   a_dev_window: assert property (p_dev_window) else $error("device drive length wrong");
   a_dev_released: assert property (p_dev_released) else $error("device drove before release");
   a_dev_sample: assert property (p_dev_sample) else $error("device data moved at clock rise");
   a_sta_sample: assert property (p_sta_sample) else $error("station data moved in high half");
   a_mdc_half: assert property (p_mdc_half) else $error("management clock high half wrong");
   a_reset_idle: assert property (p_reset_idle) else $error("bus active right after reset");
   a_pullup: assert property (p_pullup) else $error("released line not high");
endmodule // pms_mgmt_sva

// [testbench/pms_mgmt_tb.sv]
// Self-checking bench: station and device joined over the management interface.
// Assumes short station parameters; only the checker's drive window derives from them.
`timescale 1ns/100ps
module pms_mgmt_tb;
   import pms_pkg::*;
   localparam int HALF = 6;
   logic        sys_clk     = 1'b0;
   logic        rstn        = 1'b0;
   logic [4:0]  straps      = 5'h0B;
   logic        cmd_valid   = 1'b0;
   logic        cmd_write   = 1'b0;
   logic [4:0]  cmd_phy     = 5'h00;
   logic [4:0]  cmd_reg     = 5'h00;
   logic [15:0] cmd_wdata   = 16'h0000;
   logic        cmd_ready;
   logic        rsp_valid;
   logic [15:0] rsp_rdata;
   logic [4:0]  bus_address;
   logic [15:0] ctrl;
   logic [15:0] ptr;
   int          fails       = 0;
   int          comparisons = 0;
   int          done_cnt    = 0;
   logic        done;

   pms_mgmt_if mgmt ();
   always #4 sys_clk = ~sys_clk;

   // Counts commit pulses so each frame can be judged on whether it was taken
   always @(posedge sys_clk) begin
      if (done) begin
         done_cnt++;
      end
   end

   pms_mgmt_station #(.MDC_HALF(HALF), .PRE_LEN(2)) i_pms_mgmt_station (.sys_clk(sys_clk), .rstn(rstn),
      .mgmt(mgmt), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_phy(cmd_phy),
      .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   pms_mgmt_device i_pms_mgmt_device (.sys_clk(sys_clk), .rstn(rstn), .bus_address_straps(straps),
      .mgmt(mgmt), .bus_address(bus_address), .indirect_access_control(ctrl), .indirect_pointer(ptr),
      .frame_done(done));
   pms_mgmt_sva #(.MDC_HALF(HALF)) i_pms_mgmt_sva (.sys_clk(sys_clk), .rstn(rstn), .mdc(mgmt.mdc),
      .sta_mdio_val(mgmt.sta_mdio_val), .sta_mdio_en(mgmt.sta_mdio_en), .dev_mdio_val(mgmt.dev_mdio_val),
      .dev_mdio_en(mgmt.dev_mdio_en), .mdio(mgmt.mdio));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic finish_test();
      if (fails == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 3000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 3000) begin
         fails++;
         $display("Error at %0t: station never ready", $time);
      end
   endtask

   // One whole frame; the command is held until the edge that takes it
   task automatic xfer(input logic wr, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd,
                       output logic [15:0] rd);
      int n0;
      wait_ready();
      n0        = done_cnt;
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_phy   = phy;
      cmd_reg   = rg;
      cmd_wdata = wd;
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'b0;
      wait_ready();
      rd = rsp_rdata;
      chk({15'h0000, rsp_valid}, {15'h0000, !wr});
      chk(16'(done_cnt - n0), (phy == straps) ? 16'h0001 : 16'h0000);
   endtask

   task automatic wr(input logic [4:0] rg, input logic [15:0] d);
      logic [15:0] t;
      xfer(1'b1, straps, rg, d, t);
   endtask

   task automatic rd(input logic [4:0] rg, output logic [15:0] d);
      xfer(1'b0, straps, rg, 16'h0000, d);
   endtask

   task automatic set_ptr(input logic [15:0] p);
      wr(5'h0D, CTRL_SET_ADDR);
      wr(5'h0E, p);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_direct();
      logic [15:0] d;
      logic [4:0]  rg;
      chk({11'h000, bus_address}, 16'h000B);
      chk(ctrl, REG_RESET);
      chk(ptr, REG_RESET);
      for (int i = 0; i < 3; i++) begin
         rg = (i == 0) ? 5'h00 : ((i == 1) ? 5'h1F : 5'h05);
         wr(rg, 16'hA5C3 ^ {11'h000, rg});
         rd(rg, d);
         chk(d, 16'hA5C3 ^ {11'h000, rg});
      end
      xfer(1'b1, straps ^ 5'h01, 5'h05, 16'h1111, d);
      rd(5'h05, d);
      chk(d, 16'hA5C6);
      xfer(1'b0, straps ^ 5'h01, 5'h05, 16'h0000, d);
      chk(d, 16'hFFFF);
   endtask

   task automatic t_pointer();
      logic [15:0] d;
      wr(5'h0D, CTRL_SET_ADDR);
      chk(ctrl, 16'h001F);
      wr(5'h0E, 16'h0020);
      chk(ptr, 16'h0020);
      wr(5'h0E, 16'h0021);
      chk(ptr, 16'h0021);
      for (int i = 0; i < 2; i++) begin
         rd(5'h0E, d);
         chk(d, 16'h0021);
      end
   endtask

   task automatic t_functions();
      logic [15:0] c;
      logic [15:0] dat;
      logic [15:0] d;
      for (int f = 1; f < 4; f++) begin
         c   = {f[1:0], 14'h001F};
         dat = {f[3:0], 12'h0AB};
         set_ptr(16'h0028);
         wr(5'h0D, c);
         chk(ctrl, c);
         wr(5'h0E, dat);
         chk(ptr, (f == 1) ? 16'h0028 : 16'h0029);
         set_ptr(16'h0028);
         wr(5'h0D, c);
         rd(5'h0E, d);
         chk(d, dat);
         chk(ptr, (f == 2) ? 16'h0029 : 16'h0028);
      end
   endtask

   task automatic t_standard();
      logic [15:0] d;
      set_ptr(16'h0003);
      wr(5'h0D, CTRL_SET_DATA);
      wr(5'h0E, 16'h5A5A);
      rd(5'h03, d);
      chk(d, 16'h5A5A);
      set_ptr(16'h000D);
      wr(5'h0D, CTRL_SET_DATA);
      wr(5'h0E, 16'h1234);
      rd(5'h0D, d);
      chk(d, CTRL_SET_DATA);
      rd(5'h0E, d);
      chk(d, 16'h0000);
   endtask

   task automatic t_target();
      logic [15:0] d;
      set_ptr(16'h0030);
      wr(5'h0D, 16'h401E);
      wr(5'h0E, 16'hBEEF);
      chk(ptr, 16'h0030);
      rd(5'h0E, d);
      chk(d, 16'h0000);
      wr(5'h0D, CTRL_SET_DATA);
      rd(5'h0E, d);
      chk(d, 16'h0000);
   endtask

   // New straps during a second reset must become the bus address
   task automatic t_rereset();
      logic [15:0] d;
      wait_ready();
      rstn   = 1'b0;
      straps = 5'h15;
      repeat (8) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      chk({11'h000, bus_address}, 16'h0015);
      chk(ctrl, REG_RESET);
      chk(ptr, REG_RESET);
      rd(5'h00, d);
      chk(d, REG_RESET);
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      t_direct();
      t_pointer();
      t_functions();
      t_standard();
      t_target();
      t_rereset();
      finish_test();
   end

   // About 57 frames of roughly 400 cycles each
   initial begin
      repeat (60000) @(posedge sys_clk);
      fails++;
      finish_test();
   end
endmodule // pms_mgmt_tb
